// ### rtl/timebase_pkg.sv
package timebase_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam int         ADDR_W              = 8;
    localparam logic [7:0] OFF_CLOCK_CONTROL   = 8'h00;
    localparam logic [7:0] OFF_EVENT_FLAGS     = 8'h04;
    localparam logic [7:0] OFF_INT_ENABLE      = 8'h08;
    localparam logic [7:0] OFF_HOLD_ENABLE     = 8'h0c;
    localparam logic [7:0] OFF_TIMER_MODE      = 8'h10;
    localparam logic [7:0] OFF_PRESET_LOW      = 8'h14;
    localparam logic [7:0] OFF_PRESET_HIGH     = 8'h18;
    localparam logic [7:0] OFF_COMMAND         = 8'h1c;
    localparam logic [7:0] OFF_STATUS          = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CC_SUB_SELECT = 0;
    localparam int CC_MAIN_STOP  = 1;
    localparam int CC_WDT_SLOW   = 2;
    localparam int CC_SUB_SHORT  = 3;
    localparam int EV_DIV0       = 0;
    localparam int EV_TIMER      = 1;
    localparam int EV_DIV1       = 4;
    localparam int MODE_PRESCALE = 0;
    localparam int MODE_START    = 3;
    localparam int CMD_CLR_MAIN  = 0;
    localparam int CMD_CLR_SUB   = 1;
    localparam int CMD_KICK      = 2;

    // ------------------------------------------------------------
    // Widths, taps and reset values
    // ------------------------------------------------------------
    localparam int DIV0_W     = 14;
    localparam int DIV1_W     = 13;
    localparam int TAIL_W     = 4;
    localparam int WDT_W      = 4;
    localparam int TIMER_W    = 8;
    localparam int FLAG_W     = 8;
    localparam int TAP_FAST_W = 2;
    localparam int TAP_SLOW_W = 10;
    localparam logic [3:0]  CONTROL_RST = 4'h0;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic [7:0]  TIMER_RST   = 8'h00;

    typedef enum logic [0:0] {
        TIMER_IDLE = 1'b0,
        TIMER_RUN  = 1'b1
    } timer_state_t;

endpackage

// ### rtl/osc_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface osc_edge_if;
    logic level;
    logic rise;
    modport source (output level, output rise);
    modport sink   (input level, input rise);
endinterface
`default_nettype wire

// ### rtl/osc_edge_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module osc_edge_sampler (
    // Clock and reset
    input  wire logic   pclk,
    input  wire logic   presetn,
    // Oscillator pin
    input  wire logic   pin,
    // Filtered level and rising edge
    osc_edge_if.source  edge_out
);
    logic [2:0] sync;
    logic       level;
    logic       rise;
    logic       next_level;
    logic       next_rise;

    // A level only counts once the second and third stages agree.
    always_comb begin
        next_level = level;
        next_rise  = 1'b0;
        if (sync[1] == sync[2]) begin
            next_level = sync[2];
        end
        next_rise = next_level & ~level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync  <= 3'h0;
            level <= 1'b0;
            rise  <= 1'b0;
        end else begin
            sync  <= {sync[1:0], pin};
            level <= next_level;
            rise  <= next_rise;
        end
    end

    assign edge_out.level = level;
    assign edge_out.rise  = rise;
endmodule // osc_edge_sampler
`default_nettype wire

// ### rtl/timebase_watchdog_timer.sv
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module timebase_watchdog_timer #(
    parameter bit WATCHDOG_PRESENT = 1'b1
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Oscillator pins
    input  wire logic        main_osc_clock,
    input  wire logic        sub_osc_clock,
    // Core side
    input  wire logic [7:0]  int_entry_clear,
    output logic      [7:0]  event_flags,
    output logic             interrupt_request,
    output logic             hold_release,
    output logic             main_osc_stop,
    output logic             chip_reset
);
    // ------------------------------------------------------------
    // Oscillator sampling
    // ------------------------------------------------------------
    osc_edge_if main_edge ();
    osc_edge_if sub_edge ();

    osc_edge_sampler u_main_sampler (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin      (main_osc_clock),
        .edge_out (main_edge)
    );

    osc_edge_sampler u_sub_sampler (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin      (sub_osc_clock),
        .edge_out (sub_edge)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [3:0]                            clock_control;
    logic [7:0]                            int_enable;
    logic [7:0]                            hold_enable;
    logic [3:0]                            timer_mode;
    logic [7:0]                            preset;
    logic [7:0]                            timer_count;
    timebase_pkg::timer_state_t            timer_state;
    logic [timebase_pkg::DIV0_W-1:0]       div0;
    logic [timebase_pkg::DIV1_W-1:0]       div1;
    logic [timebase_pkg::WDT_W-1:0]        watchdog_counter;

    logic [3:0]                            next_clock_control;
    logic [7:0]                            next_event_flags;
    logic [7:0]                            next_int_enable;
    logic [7:0]                            next_hold_enable;
    logic [3:0]                            next_timer_mode;
    logic [7:0]                            next_preset;
    logic [7:0]                            next_timer_count;
    timebase_pkg::timer_state_t            next_timer_state;
    logic [timebase_pkg::DIV0_W-1:0]       next_div0;
    logic [timebase_pkg::DIV1_W-1:0]       next_div1;
    logic [timebase_pkg::WDT_W-1:0]        next_watchdog_counter;
    logic                                  next_chip_reset;
    logic                                  next_interrupt_request;
    logic                                  next_hold_release;
    logic [31:0]                           next_prdata;
    logic                                  next_pready;
    logic                                  next_pslverr;

    logic       wr_en;
    logic       rd_en;
    logic       mapped;
    logic       sys_tick;
    logic       tap_fast;
    logic       tap_slow;
    logic       div0_ovf;
    logic       div1_ovf;
    logic       wdt_tick;
    logic       wdt_ovf;
    logic       presc_tick;
    logic       timer_uf;
    logic       clr_main;
    logic       clr_sub;
    logic       kick;
    logic       preset_write;
    logic       mode_write;
    logic       start_write;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // The slave answers one cycle into the access phase: every write is taken
    // at the edge where pready is high, every read one edge earlier while it is low.
    always_comb begin
        wr_en  = psel & penable & pready & pwrite;
        rd_en  = psel & penable & ~pready & ~pwrite;
        mapped = 1'b1;
        case (paddr)
            timebase_pkg::OFF_CLOCK_CONTROL,
            timebase_pkg::OFF_EVENT_FLAGS,
            timebase_pkg::OFF_INT_ENABLE,
            timebase_pkg::OFF_HOLD_ENABLE,
            timebase_pkg::OFF_TIMER_MODE,
            timebase_pkg::OFF_PRESET_LOW,
            timebase_pkg::OFF_PRESET_HIGH,
            timebase_pkg::OFF_COMMAND,
            timebase_pkg::OFF_STATUS: mapped = 1'b1;
            default:                  mapped = 1'b0;
        endcase
        preset_write = wr_en & ((paddr == timebase_pkg::OFF_PRESET_LOW)
                              | (paddr == timebase_pkg::OFF_PRESET_HIGH));
        mode_write   = wr_en & (paddr == timebase_pkg::OFF_TIMER_MODE);
        start_write  = mode_write & pwdata[timebase_pkg::MODE_START];
        clr_main     = wr_en & (paddr == timebase_pkg::OFF_COMMAND)
                             & pwdata[timebase_pkg::CMD_CLR_MAIN];
        clr_sub      = wr_en & (paddr == timebase_pkg::OFF_COMMAND)
                             & pwdata[timebase_pkg::CMD_CLR_SUB];
        kick         = wr_en & (paddr == timebase_pkg::OFF_COMMAND)
                             & pwdata[timebase_pkg::CMD_KICK];

        next_pready  = psel & penable & ~pready;
        next_pslverr = psel & penable & ~pready & ~mapped;
        next_prdata  = prdata;
        if (rd_en) begin
            case (paddr)
                timebase_pkg::OFF_CLOCK_CONTROL: next_prdata = {28'h0, clock_control};
                timebase_pkg::OFF_EVENT_FLAGS:   next_prdata = {24'h0, event_flags};
                timebase_pkg::OFF_INT_ENABLE:    next_prdata = {24'h0, int_enable};
                timebase_pkg::OFF_HOLD_ENABLE:   next_prdata = {24'h0, hold_enable};
                timebase_pkg::OFF_TIMER_MODE:    next_prdata = {28'h0, timer_mode};
                timebase_pkg::OFF_PRESET_LOW:    next_prdata = {28'h0, preset[3:0]};
                timebase_pkg::OFF_PRESET_HIGH:   next_prdata = {28'h0, preset[7:4]};
                timebase_pkg::OFF_STATUS:
                    next_prdata = {14'h0, sub_edge.level, main_edge.level,
                                   watchdog_counter, 4'h0, timer_count};
                default:                         next_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------
    // Timebase, watchdog and timer
    // ------------------------------------------------------------
    always_comb begin
        // Main selected while stopped gives no tick at all.
        sys_tick = clock_control[timebase_pkg::CC_SUB_SELECT] ? sub_edge.rise
                 : (main_edge.rise & ~clock_control[timebase_pkg::CC_MAIN_STOP]);
        tap_fast = sys_tick & (&div0[timebase_pkg::TAP_FAST_W-1:0]);
        tap_slow = sys_tick & (&div0[timebase_pkg::TAP_SLOW_W-1:0]);
        div0_ovf = sys_tick & (&div0);
        div1_ovf = sub_edge.rise & (clock_control[timebase_pkg::CC_SUB_SHORT]
                 ? (&div1[timebase_pkg::DIV1_W-2:0]) : (&div1));
        wdt_tick = clock_control[timebase_pkg::CC_WDT_SLOW] ? div0_ovf : tap_slow;
        wdt_ovf  = WATCHDOG_PRESENT & wdt_tick & (&watchdog_counter) & ~kick;
        presc_tick = timer_mode[timebase_pkg::MODE_PRESCALE] ? tap_slow : tap_fast;
        timer_uf = (timer_state == timebase_pkg::TIMER_RUN) & presc_tick
                 & (timer_count == 8'h00);

        next_clock_control = clock_control;
        next_int_enable    = int_enable;
        next_hold_enable   = hold_enable;
        next_preset        = preset;
        next_timer_mode    = timer_mode;
        next_timer_count   = timer_count;
        next_timer_state   = timer_state;
        next_event_flags   = event_flags & ~int_entry_clear;

        next_div0 = div0 + {{(timebase_pkg::DIV0_W-1){1'b0}}, sys_tick};
        if (clr_main) begin
            next_div0[timebase_pkg::DIV0_W-1 -: timebase_pkg::TAIL_W] = 4'h0;
        end
        next_div1 = div1 + {{(timebase_pkg::DIV1_W-1){1'b0}}, sub_edge.rise};
        if (clr_sub) begin
            if (clock_control[timebase_pkg::CC_SUB_SHORT]) begin
                next_div1[timebase_pkg::DIV1_W-2 -: timebase_pkg::TAIL_W] = 4'h0;
            end else begin
                next_div1[timebase_pkg::DIV1_W-1 -: timebase_pkg::TAIL_W] = 4'h0;
            end
        end

        if (!WATCHDOG_PRESENT || kick) begin
            next_watchdog_counter = 4'h0;
        end else begin
            next_watchdog_counter = watchdog_counter
                                  + {3'h0, wdt_tick};
        end
        next_chip_reset = wdt_ovf;

        case (timer_state)
            timebase_pkg::TIMER_RUN: begin
                if (timer_uf) begin
                    next_timer_count = 8'hff;
                    next_timer_state = timebase_pkg::TIMER_IDLE;
                    next_timer_mode[timebase_pkg::MODE_START] = 1'b0;
                end else if (presc_tick) begin
                    next_timer_count = timer_count - 8'h01;
                end
            end
            timebase_pkg::TIMER_IDLE: begin
                next_timer_count = timer_count;
            end
            default: begin
                next_timer_state = timebase_pkg::TIMER_IDLE;
            end
        endcase

        if (wr_en) begin
            case (paddr)
                timebase_pkg::OFF_CLOCK_CONTROL: next_clock_control = pwdata[3:0];
                timebase_pkg::OFF_INT_ENABLE:    next_int_enable    = pwdata[7:0];
                timebase_pkg::OFF_HOLD_ENABLE:   next_hold_enable   = pwdata[7:0];
                timebase_pkg::OFF_PRESET_LOW:    next_preset[3:0]   = pwdata[3:0];
                timebase_pkg::OFF_PRESET_HIGH:   next_preset[7:4]   = pwdata[3:0];
                default:                         next_preset        = preset;
            endcase
        end
        if (preset_write) begin
            next_timer_count = next_preset;
            next_timer_state = timebase_pkg::TIMER_IDLE;
            next_timer_mode[timebase_pkg::MODE_START] = 1'b0;
        end
        if (mode_write) begin
            next_timer_mode = {pwdata[3], 2'h0, pwdata[0]};
            next_timer_state = timebase_pkg::TIMER_IDLE;
        end
        if (start_write) begin
            next_timer_count = preset;
            next_timer_state = timebase_pkg::TIMER_RUN;
            next_event_flags[timebase_pkg::EV_TIMER] = 1'b0;
        end

        // Sets come last so an event never drowns in a clear.
        if (div0_ovf) begin
            next_event_flags[timebase_pkg::EV_DIV0] = 1'b1;
        end
        if (div1_ovf) begin
            next_event_flags[timebase_pkg::EV_DIV1] = 1'b1;
        end
        if (timer_uf) begin
            next_event_flags[timebase_pkg::EV_TIMER] = 1'b1;
        end
        next_interrupt_request = |(next_event_flags & next_int_enable);
        next_hold_release      = |(next_event_flags & next_hold_enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_control     <= timebase_pkg::CONTROL_RST;
            event_flags       <= timebase_pkg::FLAGS_RST;
            int_enable        <= timebase_pkg::FLAGS_RST;
            hold_enable       <= timebase_pkg::FLAGS_RST;
            timer_mode        <= timebase_pkg::CONTROL_RST;
            preset            <= timebase_pkg::TIMER_RST;
            timer_count       <= timebase_pkg::TIMER_RST;
            timer_state       <= timebase_pkg::TIMER_IDLE;
            div0              <= '0;
            div1              <= '0;
            watchdog_counter  <= '0;
            chip_reset        <= 1'b0;
            interrupt_request <= 1'b0;
            hold_release      <= 1'b0;
        end else begin
            clock_control     <= next_clock_control;
            event_flags       <= next_event_flags;
            int_enable        <= next_int_enable;
            hold_enable       <= next_hold_enable;
            timer_mode        <= next_timer_mode;
            preset            <= next_preset;
            timer_count       <= next_timer_count;
            timer_state       <= next_timer_state;
            div0              <= next_div0;
            div1              <= next_div1;
            watchdog_counter  <= next_watchdog_counter;
            chip_reset        <= next_chip_reset;
            interrupt_request <= next_interrupt_request;
            hold_release      <= next_hold_release;
        end
    end

    assign main_osc_stop = clock_control[timebase_pkg::CC_MAIN_STOP];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_access_wait;
        psel && penable && !pready;
    endsequence
    sequence seq_one_pulse;
        chip_reset ##1 !chip_reset;
    endsequence

    AST_DIV0_COUNT: assert property (sys_tick && !clr_main |=>
        div0 == 14'($past(div0) + 14'h0001))
        else $error("main divider did not advance");
    AST_DIV0_FLAG: assert property (div0_ovf |=> event_flags[0])
        else $error("main divider overflow lost");
    AST_TAIL_CLEAR: assert property (clr_main |=> div0[13:10] == 4'h0 &&
        div0[9:0] == 10'($past(div0[9:0]) + 10'($past(sys_tick))))
        else $error("main divider tail clear wrong");
    AST_DIV1_FLAG: assert property ($rose(event_flags[4]) |-> $past(div1_ovf))
        else $error("sub divider flag without overflow");
    AST_SOURCE: assert property (clock_control[0] |-> sys_tick == sub_edge.rise)
        else $error("system tick not from sub clock");
    AST_MAIN_STOPPED: assert property (clock_control[1] && !clock_control[0]
        |-> !sys_tick)
        else $error("tick while main stopped");
    AST_PRESET_HALT: assert property (preset_write |=> !timer_mode[3] &&
        timer_state == timebase_pkg::TIMER_IDLE && timer_count == preset)
        else $error("preset write did not halt and load");
    AST_START: assert property (start_write && !timer_uf |=>
        timer_state == timebase_pkg::TIMER_RUN && !event_flags[1] &&
        timer_count == $past(preset))
        else $error("start did not reload timer");
    AST_UNDERFLOW: assert property (timer_uf && !wr_en |=>
        timer_count == 8'hff && event_flags[1] &&
        timer_state == timebase_pkg::TIMER_IDLE)
        else $error("timer underflow handling wrong");
    AST_WDT_RESET: assert property (wdt_ovf |=> seq_one_pulse)
        else $error("watchdog reset pulse wrong");
    AST_KICK: assert property (kick |=> watchdog_counter == 4'h0)
        else $error("kick did not zero watchdog");
    AST_REQUEST: assert property (interrupt_request ==
        |(event_flags & int_enable))
        else $error("request does not follow flags");
    AST_APB_READY: assert property (seq_access_wait |=> pready ##1 !pready)
        else $error("apb answer timing wrong");
endmodule // timebase_watchdog_timer
`default_nettype wire

// ### tb/osc_model.sv
`timescale 1ns/1ps
`default_nettype none
// Both crystals run free; the main one halts while the block asks it to stop.
module osc_model #(
    parameter int HALF = 3
) (
    // Clock and stop request
    input  wire logic pclk,
    input  wire logic main_osc_stop,
    // Oscillator pins
    output logic      main_osc_clock,
    output logic      sub_osc_clock
);
    int   cnt = 0;
    logic main_q = 1'b0;
    logic sub_q = 1'b0;
    assign main_osc_clock = main_q;
    assign sub_osc_clock  = sub_q;
    always @(posedge pclk) begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1) begin
            sub_q <= ~sub_q;
            if (!main_osc_stop) main_q <= ~main_q;
        end
    end
endmodule // osc_model
`default_nettype wire

// ### tb/mcu_timebase_watchdog_timer_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcu_timebase_watchdog_timer_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  int_entry_clear = 8'h00;
    logic [31:0] prdata, rd;
    logic [7:0]  event_flags, p;
    logic        pready, pslverr, err, main_osc_clock, sub_osc_clock, fired = 1'b0;
    logic        interrupt_request, hold_release, main_osc_stop, chip_reset;
    int          mismatches = 0, compares = 0, seed = 32'h2a624b87, n, t;
    int          mdl [0:3] = '{0, 0, 0, 0};
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) if (chip_reset === 1'b1) fired <= 1'b1;
    timebase_watchdog_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_osc_clock(main_osc_clock), .sub_osc_clock(sub_osc_clock),
        .int_entry_clear(int_entry_clear), .event_flags(event_flags),
        .interrupt_request(interrupt_request), .hold_release(hold_release),
        .main_osc_stop(main_osc_stop), .chip_reset(chip_reset));
    osc_model u_osc (.pclk(pclk), .main_osc_stop(main_osc_stop),
        .main_osc_clock(main_osc_clock), .sub_osc_clock(sub_osc_clock));
    task automatic report_and_stop;
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            report_and_stop();
        end
        #1;
    endtask
    // The model keeps what software wrote to clock control and the interrupt and hold enables.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        if (a < 8'h10) mdl[a >> 2] = d & ((a == 8'h00) ? 32'hf : 32'hff);
        if (a == 8'h04) mdl[1] = 0;
    endtask
    task automatic rb(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
        check("register read-back", rd, mdl[a >> 2]);
    endtask
    task automatic wait_flag(input int b, input int lim);
        t = 0;
        while (event_flags[b] !== 1'b1) begin
            @(posedge pclk);
            t++;
            if (t > lim) begin
                mismatches++;
                report_and_stop();
            end
        end
    endtask
    task automatic entry_clear(input logic [7:0] m);
        @(posedge pclk);
        int_entry_clear <= m;
        @(posedge pclk);
        int_entry_clear <= 8'h00;
        @(posedge pclk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        for (int i = 0; i < 4; i++) rb(8'(i * 4));
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        check("unmapped data", rd, 32'h0);
        wr(timebase_pkg::OFF_INT_ENABLE, 32'h02);
        rb(timebase_pkg::OFF_INT_ENABLE);
        p = (8'($random(seed)) & 8'h1f) | 8'h10;
        wr(timebase_pkg::OFF_PRESET_HIGH, {28'h0, p[7:4]});
        wr(timebase_pkg::OFF_PRESET_LOW, {28'h0, p[3:0]});
        apb(1'b0, timebase_pkg::OFF_STATUS, 32'h0);
        check("loaded count", rd[7:0], p);
        wr(timebase_pkg::OFF_TIMER_MODE, 32'h8);
        wait_flag(1, 800);
        check("fast interval", 32'(t >= 24 * p && t <= 24 * p + 30), 32'h1);
        check("timer request", 32'(interrupt_request), 32'h1);
        apb(1'b0, timebase_pkg::OFF_TIMER_MODE, 32'h0);
        check("start cleared", rd, 32'h0);
        apb(1'b0, timebase_pkg::OFF_STATUS, 32'h0);
        check("wrapped count", rd[7:0], 8'hff);
        check("no hold release", 32'(hold_release), 32'h0);
        wr(timebase_pkg::OFF_HOLD_ENABLE, 32'h02);
        check("hold release", 32'(hold_release), 32'h1);
        wr(timebase_pkg::OFF_TIMER_MODE, 32'h8);
        check("start clears flag", 32'(event_flags[1]), 32'h0);
        wr(timebase_pkg::OFF_PRESET_LOW, 32'h5);
        apb(1'b0, timebase_pkg::OFF_TIMER_MODE, 32'h0);
        check("preset stops timer", rd, 32'h0);
        apb(1'b0, timebase_pkg::OFF_STATUS, 32'h0);
        check("preset reload", rd[7:0], {p[7:4], 4'h5});
        // Move to the sub clock: source first, then stop the main oscillator.
        wr(timebase_pkg::OFF_CLOCK_CONTROL, 32'hc);
        wr(timebase_pkg::OFF_CLOCK_CONTROL, 32'hd);
        wr(timebase_pkg::OFF_CLOCK_CONTROL, 32'hf);
        check("main stop", 32'(main_osc_stop), 32'h1);
        rb(timebase_pkg::OFF_CLOCK_CONTROL);
        wr(timebase_pkg::OFF_COMMAND, 32'h6);
        wait_flag(4, 24700);
        check("sub interval", 32'(t >= 23000 && t <= 24620), 32'h1);
        check("sub masked", 32'(interrupt_request), 32'h0);
        wr(timebase_pkg::OFF_INT_ENABLE, 32'h12);
        check("sub request", 32'(interrupt_request), 32'h1);
        entry_clear(8'h10);
        check("entry clear", 32'({event_flags, interrupt_request}), 32'h0);
        // Back to the main clock: restart it, let it settle, then select it.
        wr(timebase_pkg::OFF_CLOCK_CONTROL, 32'hd);
        repeat (30) @(posedge pclk);
        wr(timebase_pkg::OFF_CLOCK_CONTROL, 32'h8);
        check("main running", 32'(main_osc_stop), 32'h0);
        rb(timebase_pkg::OFF_CLOCK_CONTROL);
        wr(timebase_pkg::OFF_PRESET_HIGH, 32'h0);
        wr(timebase_pkg::OFF_PRESET_LOW, 32'h1);
        wr(timebase_pkg::OFF_COMMAND, 32'h4);
        wr(timebase_pkg::OFF_TIMER_MODE, 32'h9);
        wait_flag(1, 12400);
        check("slow interval", 32'(t >= 6144 && t <= 12320), 32'h1);
        apb(1'b0, timebase_pkg::OFF_TIMER_MODE, 32'h0);
        check("prescale kept", rd, 32'h1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mdl = '{0, 0, 0, 0};
        for (int i = 0; i < 4; i++) rb(8'(i * 4));
        check("reset flags", 32'({event_flags, interrupt_request}), 32'h0);
        check("reset hold", 32'({hold_release, main_osc_stop}), 32'h0);
        check("no watchdog reset", 32'(fired), 32'h0);
        report_and_stop();
    end
endmodule // mcu_timebase_watchdog_timer_tb_top
`default_nettype wire
